// ===== bench/ptc_tick_counter_tb.sv
// self-checking testbench for the prescaled modulo tick counter
`timescale 1ns/1ps
module ptc_tick_counter_tb;
  //////////////////////////////////////////////////////////////////////
  // stimulus and observed signals
  logic clk_sys; // 40 MHz system clock, also the bus source
  logic reset_n; // active-low reset into the design
  logic [2:0] pin; // ext osc, low-power osc, reference clock pins
  logic sc_write, wr_clear, wr_ie, wr_te; // control write group
  logic [2:0] wr_ps; // prescale code to write
  logic [1:0] wr_cs; // clock source code to write
  logic mod_write; // modulo write strobe
  logic [15:0] mod_data; // modulo write data
  logic low_read; // low byte read strobe
  logic [15:0] count_value, modulo_value;
  logic [7:0] count_high;
  logic [2:0] ps_out;
  logic [1:0] cs_out;
  logic flag, irq_en, tog_en, irq, tog_pin;
  int error_cnt = 0; // mismatches seen
  int samples_checked = 0; // comparisons made
  // bus-source divisors per prescale code, index 0 unused
  int bus_div [0:7] = '{0, 128, 256, 512, 1024, 2048, 100, 1000};

  //////////////////////////////////////////////////////////////////////
  // device under test; every input is driven by the bench
  ptc_tick_counter uut (
    .i_clk_sys(clk_sys), .i_reset_n(reset_n),
    .i_ext_osc(pin[0]), .i_low_power_osc(pin[1]), .i_int_ref_clk(pin[2]),
    .i_sc_write(sc_write), .i_wr_clear_flag(wr_clear),
    .i_wr_irq_enable(wr_ie), .i_wr_toggle_enable(wr_te),
    .i_wr_prescale_select(wr_ps), .i_wr_clock_source_select(wr_cs),
    .i_mod_write(mod_write), .i_wr_modulo_value(mod_data),
    .i_count_low_read(low_read), .o_count_value(count_value),
    .o_count_high_held(count_high), .o_modulo_value(modulo_value),
    .o_prescale_select(ps_out), .o_clock_source_select(cs_out),
    .o_match_flag(flag), .o_match_irq_enable(irq_en),
    .o_toggle_output_enable(tog_en), .o_irq(irq), .o_toggle_pin(tog_pin)
  );

  //////////////////////////////////////////////////////////////////////
  // clock: 25 ns period
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  //////////////////////////////////////////////////////////////////////
  // helpers; every drive and sample lands 2 ns after a rising edge
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // whole control write; an extra edge keeps strobes from re-rising
  task automatic sc(input logic c, input logic e, input logic t,
                    input logic [2:0] p, input logic [1:0] s);
    sc_write = 1'b1;
    wr_clear = c;
    wr_ie = e;
    wr_te = t;
    wr_ps = p;
    wr_cs = s;
    tick();
    sc_write = 1'b0;
    tick();
  endtask

  task automatic modw(input logic [15:0] v);
    mod_write = 1'b1;
    mod_data = v;
    tick();
    mod_write = 1'b0;
    tick();
  endtask

  // waits for the count to move; n is the cycles it took
  task automatic wait_chg(output logic [15:0] v, output int n);
    logic [15:0] prev;
    prev = count_value;
    n = 0;
    do begin
      tick();
      n++;
    end while (count_value === prev && n < 3000);
    if (n >= 3000) chk("count change timeout", 16'h0001, 16'h0000);
    v = count_value;
  endtask

  task automatic wait_flag();
    int n;
    n = 0;
    while (flag !== 1'b1 && n < 300) begin
      tick();
      n++;
    end
    if (n >= 300) chk("match flag timeout", 16'h0001, 16'h0000);
  endtask

  //////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    reset_n = 1'b0;
    tick(3);
    reset_n = 1'b1;
    tick(3); // writes before the third cycle would be lost
    chk("count", 16'h0000, count_value);
    chk("modulo", 16'h0000, modulo_value);
    chk("prescale", 16'h0000, {13'h0000, ps_out});
    chk("source", 16'h0000, {14'h0000, cs_out});
    chk("flag", 16'h0000, {15'h0000, flag});
    chk("irq enable", 16'h0000, {15'h0000, irq_en});
    chk("irq and pin", 16'h0000, {14'h0000, irq, tog_pin});
  endtask

  // bus source: gap between count steps for each prescale code 1 to 7
  task automatic t_bus_periods();
    logic [15:0] v;
    int n;
    modw(16'hFFFF);
    sc(1'b0, 1'b0, 1'b0, 3'h0, 2'h3);
    tick(300);
    chk("count while off", 16'h0000, count_value);
    for (int p = 1; p < 8; p++) begin
      sc(1'b0, 1'b0, 1'b0, p[2:0], 2'h3);
      chk("count after code change", 16'h0000, count_value);
      chk("prescale code", {13'h0000, p[2:0]}, {13'h0000, ps_out});
      wait_chg(v, n);
      wait_chg(v, n);
      chk("bus period", bus_div[p][15:0], n[15:0]);
    end
  endtask

  // pin sources: count source edges through the divider
  task automatic src_run(input logic [1:0] s, input logic [2:0] p,
                         input int edges, input logic [15:0] exp);
    sc(1'b0, 1'b0, 1'b0, 3'h0, s);
    sc(1'b0, 1'b0, 1'b0, p, s); // reloads comparator from 0xFFFF
    chk("source code", {14'h0000, s}, {14'h0000, cs_out});
    repeat (edges) begin
      pin[s] = 1'b1;
      tick(2);
      pin[s] = 1'b0;
      tick(2);
    end
    tick(8);
    chk("pin source count", exp, count_value);
  endtask

  task automatic t_sources();
    src_run(2'h1, 3'h1, 128, 16'h0001);
    src_run(2'h2, 3'h3, 12, 16'h0003);
    src_run(2'h0, 3'h1, 300, 16'h012C);
    // split read of the 16-bit count, low byte first
    low_read = 1'b1;
    chk("count low byte", 16'h002C, {8'h00, count_value[7:0]});
    tick();
    low_read = 1'b0;
    chk("count high held", 16'h0001, {8'h00, count_high});
    sc(1'b0, 1'b0, 1'b0, 3'h1, 2'h1);
    chk("count after source change", 16'h0000, count_value);
    chk("count high stands", 16'h0001, {8'h00, count_high});
  endtask

  // new modulo waits for the next wrap
  task automatic t_modulo();
    logic [15:0] v;
    int n;
    logic [15:0] exp [0:7] = '{16'h0002, 16'h0000, 16'h0001, 16'h0002,
                               16'h0003, 16'h0004, 16'h0005, 16'h0000};
    modw(16'h0002);
    sc(1'b0, 1'b0, 1'b0, 3'h0, 2'h3);
    sc(1'b0, 1'b0, 1'b0, 3'h6, 2'h3);
    wait_chg(v, n);
    chk("first step", 16'h0001, v);
    modw(16'h0005);
    chk("modulo register", 16'h0005, modulo_value);
    for (int i = 0; i < 8; i++) begin
      wait_chg(v, n);
      chk("count sequence", exp[i], v);
      if (i == 0) chk("flag before wrap", 16'h0000, {15'h0, flag});
      if (i == 1) chk("flag at wrap", 16'h0001, {15'h0, flag});
    end
  endtask

  // modulo zero: every prescaler output wraps and flags; the pin toggles only while enabled
  task automatic t_flag();
    logic p0;
    modw(16'h0000);
    sc(1'b1, 1'b1, 1'b1, 3'h0, 2'h3);
    chk("enables set", 16'h0003, {14'h0, irq_en, tog_en});
    sc(1'b1, 1'b1, 1'b1, 3'h6, 2'h3);
    chk("flag cleared", 16'h0000, {15'h0, flag});
    p0 = tog_pin;
    wait_flag();
    tick();
    chk("irq on flag", 16'h0001, {15'h0, irq});
    chk("pin toggled", {15'h0, ~p0}, {15'h0, tog_pin});
    sc(1'b0, 1'b1, 1'b1, 3'h6, 2'h3);
    chk("flag after zero write", 16'h0001, {15'h0, flag});
    sc(1'b1, 1'b1, 1'b1, 3'h6, 2'h3);
    chk("flag and irq cleared", 16'h0000, {14'h0, flag, irq});
    wait_flag();
    tick();
    chk("pin back", {15'h0, p0}, {15'h0, tog_pin});
    sc(1'b0, 1'b0, 1'b0, 3'h6, 2'h3);
    chk("irq masked", 16'h0000, {15'h0, irq});
    chk("enables cleared", 16'h0000, {14'h0, irq_en, tog_en});
    sc(1'b1, 1'b0, 1'b0, 3'h6, 2'h3);
    wait_flag();
    tick();
    chk("pin held", {15'h0, p0}, {15'h0, tog_pin});
    chk("flag with mask", 16'h0001, {15'h0, flag});
  endtask

  //////////////////////////////////////////////////////////////////////
  // verdict, reached from the main sequence or the watchdog
  task automatic conclude();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // watchdog: the run needs about 13500 cycles
  initial begin
    #1ms;
    error_cnt++;
    conclude();
  end

  // main sequence
  initial begin
    reset_n = 1'b0;
    pin = 3'h0;
    sc_write = 1'b0;
    wr_clear = 1'b0;
    wr_ie = 1'b0;
    wr_te = 1'b0;
    wr_ps = 3'h0;
    wr_cs = 2'h0;
    mod_write = 1'b0;
    mod_data = 16'h0000;
    low_read = 1'b0;
    t_reset();
    t_bus_periods();
    t_sources();
    t_modulo();
    t_flag();
    t_reset();
    conclude();
  end
endmodule // ptc_tick_counter_tb

// ===== design/ptc_edge_sync.sv
// two-flop synchronisers with rising-edge pulses for source pins
`timescale 1ns/1ps
module ptc_edge_sync #(
  parameter int WIDTH = 3
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [WIDTH-1:0] i_level,
  output logic [WIDTH-1:0] o_rise
);

  //////////////////////////////////////////////////////////////////////
  // per source: metastable stage, stable stage, previous stable value
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_src
      logic meta; // read only by the stable stage
      logic stable; // safe synchronised level
      logic prev; // last stable level, for edge finding
      logic next_meta;
      logic next_stable;
      logic next_prev;

      // next values of the chain
      always_comb begin
        next_meta = i_level[g];
        next_stable = meta;
        next_prev = stable;
      end

      // registers; reset low so no false edge after release
      always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
          meta <= 1'b0;
          stable <= 1'b0;
          prev <= 1'b0;
        end else begin
          meta <= next_meta;
          stable <= next_stable;
          prev <= next_prev;
        end
      end

      // one-cycle pulse per source rising edge
      assign o_rise[g] = stable & ~prev;
    end
  endgenerate

endmodule // ptc_edge_sync

// ===== design/ptc_prescaler.sv
// prescaler: divides source ticks into one-cycle count enables
`timescale 1ns/1ps
module ptc_prescaler (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_src_tick,
  input wire logic i_clear,
  input wire logic [2:0] i_prescale_select,
  input wire logic i_group1,
  output logic o_tick
);

  logic [ptc_pkg::DIV_W-1:0] div_cnt; // source ticks seen this period
  logic [ptc_pkg::DIV_W-1:0] next_div_cnt;
  logic tick; // registered count enable
  logic next_tick;
  logic [ptc_pkg::DIV_W-1:0] limit; // divisor for current codes

  //////////////////////////////////////////////////////////////////////
  // divisor lookup and period counting
  always_comb begin
    // group 1: binary codes first, decimal codes 110 and 111; group 0 all binary
    if (i_group1) begin
      limit = ptc_pkg::DIV_GROUP1[i_prescale_select];
    end else begin
      limit = ptc_pkg::DIV_GROUP0[i_prescale_select];
    end
    next_div_cnt = div_cnt;
    next_tick = 1'b0;
    if (i_clear || i_prescale_select == ptc_pkg::PS_OFF) begin
      // held at zero while off or on a selection change
      next_div_cnt = '0;
    end else if (i_src_tick) begin
      if (div_cnt == limit - 12'h001) begin
        // one single-cycle enable per period
        next_div_cnt = '0;
        next_tick = 1'b1;
      end else begin
        next_div_cnt = div_cnt + 12'h001;
      end
    end
  end

  // registers; reset leaves the prescaler idle
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_cnt <= '0;
      tick <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      tick <= next_tick;
    end
  end

  assign o_tick = tick;

  //////////////////////////////////////////////////////////////////////
  // checks
  chk_off_no_tick: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_prescale_select == ptc_pkg::PS_OFF) |=> !o_tick
  ) else $error("prescaler produced an enable while off");

  chk_tick_one_cycle: assert property (
    @(posedge i_clk_sys) disable iff (!i_rst_n)
    o_tick && limit != 12'h001 |=> !o_tick
  ) else $error("count enable wider than one cycle");

endmodule // ptc_prescaler

// ===== design/ptc_tick_counter.sv
// prescaled modulo tick counter: selector, counter, flag, pin toggle
`timescale 1ns/1ps
module ptc_tick_counter (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_ext_osc,
  input wire logic i_low_power_osc,
  input wire logic i_int_ref_clk,
  input wire logic i_sc_write,
  input wire logic i_wr_clear_flag,
  input wire logic i_wr_irq_enable,
  input wire logic i_wr_toggle_enable,
  input wire logic [2:0] i_wr_prescale_select,
  input wire logic [1:0] i_wr_clock_source_select,
  input wire logic i_mod_write,
  input wire logic [15:0] i_wr_modulo_value,
  input wire logic i_count_low_read,
  output logic [15:0] o_count_value,
  output logic [7:0] o_count_high_held,
  output logic [15:0] o_modulo_value,
  output logic [2:0] o_prescale_select,
  output logic [1:0] o_clock_source_select,
  output logic o_match_flag,
  output logic o_match_irq_enable,
  output logic o_toggle_output_enable,
  output logic o_irq,
  output logic o_toggle_pin
);

  //////////////////////////////////////////////////////////////////////
  // reset release synchroniser
  logic rst_q1; // first stage, read only by second
  logic rst_n; // released copy used everywhere else

  // asserts at once, releases two edges later
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // state
  logic [1:0] clk_src_sel; // selected source code
  logic [1:0] next_clk_src_sel;
  logic [2:0] prescale_sel; // prescale code, zero means off
  logic [2:0] next_prescale_sel;
  logic [15:0] modulo_reg; // software-visible modulo
  logic [15:0] next_modulo_reg;
  logic [15:0] active_mod; // value the comparator really uses
  logic [15:0] next_active_mod;
  logic [15:0] count; // the up-counter
  logic [15:0] next_count;
  logic [7:0] count_high; // high byte caught on low-byte read
  logic [7:0] next_count_high;
  logic match_flag; // sticky wrap flag
  logic next_match_flag;
  logic irq_en; // interrupt enable
  logic next_irq_en;
  logic toggle_en; // pin toggle enable
  logic next_toggle_en;
  logic toggle_pin; // output pin level
  logic next_toggle_pin;

  //////////////////////////////////////////////////////////////////////
  // source pins into the system clock
  logic [ptc_pkg::SRC_N-1:0] src_rise; // one pulse per source edge
  logic src_tick; // edge of the selected source
  logic pre_tick; // prescaler count enable

  // pins cross two flops before any edge logic looks at them
  ptc_edge_sync #(
    .WIDTH(ptc_pkg::SRC_N)
  ) u_edge_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(rst_n),
    .i_level({i_int_ref_clk, i_low_power_osc, i_ext_osc}),
    .o_rise(src_rise)
  );

  // source selector feeding the prescaler
  always_comb begin
    unique case (clk_src_sel)
      ptc_pkg::CS_EXT_OSC: src_tick = src_rise[ptc_pkg::SRC_EXT_OSC];
      ptc_pkg::CS_LOW_POWER: src_tick = src_rise[ptc_pkg::SRC_LOW_POWER];
      ptc_pkg::CS_INT_REF: src_tick = src_rise[ptc_pkg::SRC_INT_REF];
      // bus clock is the system clock: every cycle is a source tick
      ptc_pkg::CS_BUS: src_tick = 1'b1;
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // control decode
  logic src_change; // new source code written
  logic ps_change; // new prescale code written
  logic restart; // clear prescaler and counter
  logic ps_start; // prescaler selected nonzero
  logic wrap; // counter steps from modulo to zero
  logic flag_clear; // software writes one to the flag

  always_comb begin
    src_change = i_sc_write && (i_wr_clock_source_select != clk_src_sel);
    ps_change = i_sc_write && (i_wr_prescale_select != prescale_sel);
    restart = src_change || ps_change;
    ps_start = ps_change && (i_wr_prescale_select != ptc_pkg::PS_OFF);
    // a write of zero to the flag bit leaves it alone
    flag_clear = i_sc_write && i_wr_clear_flag;
    // modulo zero wraps on every enable
    wrap = pre_tick && !restart && (count == active_mod);
  end

  // prescaler; codes only reach it through the registers
  ptc_prescaler u_prescaler (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(rst_n),
    .i_src_tick(src_tick),
    .i_clear(restart),
    .i_prescale_select(prescale_sel),
    .i_group1(clk_src_sel[0]),
    .o_tick(pre_tick)
  );

  //////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    next_clk_src_sel = clk_src_sel;
    next_prescale_sel = prescale_sel;
    next_irq_en = irq_en;
    next_toggle_en = toggle_en;
    next_modulo_reg = modulo_reg;
    next_active_mod = active_mod;
    next_count = count;
    next_count_high = count_high;
    next_toggle_pin = toggle_pin;
    // software control writes
    if (i_sc_write) begin
      next_clk_src_sel = i_wr_clock_source_select;
      next_prescale_sel = i_wr_prescale_select;
      next_irq_en = i_wr_irq_enable;
      next_toggle_en = i_wr_toggle_enable;
    end
    if (i_mod_write) begin
      next_modulo_reg = i_wr_modulo_value;
    end
    // comparator copy refreshed only at wrap or start
    if (wrap || ps_start) begin
      next_active_mod = modulo_reg;
    end
    // counter: clear on selection change, wrap, else step
    if (restart) begin
      next_count = ptc_pkg::COUNT_RESET;
    end else if (wrap) begin
      next_count = ptc_pkg::COUNT_RESET;
    end else if (pre_tick) begin
      next_count = count + 16'h0001;
    end
    // high byte frozen so the two byte reads agree
    if (i_count_low_read) begin
      next_count_high = count[15:8];
    end
    // pin inverts from its own previous level
    if (wrap && toggle_en) begin
      next_toggle_pin = ~toggle_pin;
    end
    // set wins over a clear in the same cycle
    next_match_flag = (match_flag && !flag_clear) || wrap;
  end

  //////////////////////////////////////////////////////////////////////
  // registers; reset state
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clk_src_sel <= ptc_pkg::CS_RESET;
      prescale_sel <= ptc_pkg::PS_OFF;
      modulo_reg <= ptc_pkg::MODULO_RESET;
      active_mod <= ptc_pkg::MODULO_RESET;
      count <= ptc_pkg::COUNT_RESET;
      count_high <= 8'h00;
      match_flag <= 1'b0;
      irq_en <= 1'b0;
      toggle_en <= 1'b0;
      toggle_pin <= 1'b0;
    end else begin
      clk_src_sel <= next_clk_src_sel;
      prescale_sel <= next_prescale_sel;
      modulo_reg <= next_modulo_reg;
      active_mod <= next_active_mod;
      count <= next_count;
      count_high <= next_count_high;
      match_flag <= next_match_flag;
      irq_en <= next_irq_en;
      toggle_en <= next_toggle_en;
      toggle_pin <= next_toggle_pin;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // outputs; there is no write path to the count at all
  assign o_count_value = count;
  assign o_count_high_held = count_high;
  assign o_modulo_value = modulo_reg;
  assign o_prescale_select = prescale_sel;
  assign o_clock_source_select = clk_src_sel;
  assign o_match_flag = match_flag;
  assign o_match_irq_enable = irq_en;
  assign o_toggle_output_enable = toggle_en;
  assign o_toggle_pin = toggle_pin;
  // request follows flag and enable; clearing the flag drops it
  assign o_irq = match_flag & irq_en;

  //////////////////////////////////////////////////////////////////////
  // checks
  chk_wrap_sets_flag: assert property (
    @(posedge i_clk_sys) disable iff (!rst_n)
    wrap |=> (o_match_flag && o_count_value == 16'h0000)
  ) else $error("wrap did not set flag and zero the count");

  chk_count_steps: assert property (
    @(posedge i_clk_sys) disable iff (!rst_n)
    pre_tick && !restart && count != active_mod
      |=> count == $past(count) + 16'h0001
  ) else $error("counter did not step by one");

  chk_count_idle: assert property (
    @(posedge i_clk_sys) disable iff (!rst_n)
    !pre_tick && !restart |=> $stable(count)
  ) else $error("counter moved without an enable");

  chk_src_clears: assert property (
    @(posedge i_clk_sys) disable iff (!rst_n)
    src_change |=> (count == 16'h0000 && !pre_tick)
  ) else $error("source change did not clear the counter");

  chk_ps_clears: assert property (
    @(posedge i_clk_sys) disable iff (!rst_n)
    ps_change |=> (count == 16'h0000 && !pre_tick)
  ) else $error("prescale change did not clear the counter");

  chk_flag_clear: assert property (
    @(posedge i_clk_sys) disable iff (!rst_n)
    flag_clear && !wrap |=> (!o_match_flag && !o_irq)
  ) else $error("writing one did not clear the flag");

  chk_flag_keep: assert property (
    @(posedge i_clk_sys) disable iff (!rst_n)
    o_match_flag && !flag_clear |=> o_match_flag
  ) else $error("flag dropped without a clear");

  chk_irq_raise: assert property (
    @(posedge i_clk_sys) disable iff (!rst_n)
    wrap && irq_en && !i_sc_write |=> o_irq
  ) else $error("enabled wrap did not request an interrupt");

  chk_pin_toggle: assert property (
    @(posedge i_clk_sys) disable iff (!rst_n)
    wrap && toggle_en |=> o_toggle_pin != $past(o_toggle_pin)
  ) else $error("pin did not invert on wrap");

  chk_pin_hold: assert property (
    @(posedge i_clk_sys) disable iff (!rst_n)
    !(wrap && toggle_en) |=> $stable(o_toggle_pin)
  ) else $error("pin moved without a wrap");

  chk_mod_latched: assert property (
    @(posedge i_clk_sys) disable iff (!rst_n)
    !wrap && !ps_start |=> $stable(active_mod)
  ) else $error("comparator value changed outside wrap or start");

  chk_mod_zero: assert property (
    @(posedge i_clk_sys) disable iff (!rst_n)
    pre_tick && !restart && active_mod == 16'h0000 |=> o_match_flag
  ) else $error("modulo zero did not flag on an enable");

  chk_ctrl_write: assert property (
    @(posedge i_clk_sys) disable iff (!rst_n)
    i_sc_write |=> (o_prescale_select == $past(i_wr_prescale_select) &&
      o_clock_source_select == $past(i_wr_clock_source_select))
  ) else $error("control write did not reach the select fields");

  chk_mod_write: assert property (
    @(posedge i_clk_sys) disable iff (!rst_n)
    i_mod_write |=> o_modulo_value == $past(i_wr_modulo_value)
  ) else $error("modulo write was not stored");

  chk_mod_reload: assert property (
    @(posedge i_clk_sys) disable iff (!rst_n)
    wrap || ps_start |=> active_mod == $past(modulo_reg)
  ) else $error("comparator did not take the stored modulo");

  chk_high_capture: assert property (
    @(posedge i_clk_sys) disable iff (!rst_n)
    i_count_low_read |=> o_count_high_held == $past(count[15:8])
  ) else $error("high byte not caught on the low byte read");

  chk_high_hold: assert property (
    @(posedge i_clk_sys) disable iff (!rst_n)
    !i_count_low_read |=> $stable(o_count_high_held)
  ) else $error("held high byte moved without a read");

endmodule // ptc_tick_counter

// ===== pkg/ptc_pkg.sv
// constants and types shared by the prescaled modulo tick counter
package ptc_pkg;

  //////////////////////////////////////////////////////////////////////
  // widths
  localparam int CNT_W = 16; // counter and modulo width
  localparam int PS_W = 3; // prescale select width
  localparam int CS_W = 2; // clock source select width
  localparam int DIV_W = 12; // prescaler divisor width, up to 2048
  localparam int SRC_N = 3; // pin-driven clock sources

  //////////////////////////////////////////////////////////////////////
  // reset values and select codes
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] MODULO_RESET = 16'h0000;
  localparam logic [2:0] PS_OFF = 3'h0; // prescaler stopped
  localparam logic [1:0] CS_EXT_OSC = 2'h0; // external_oscillator
  localparam logic [1:0] CS_LOW_POWER = 2'h1; // low_power_oscillator
  localparam logic [1:0] CS_INT_REF = 2'h2; // 32.768 kHz reference
  localparam logic [1:0] CS_BUS = 2'h3; // bus clock
  localparam logic [1:0] CS_RESET = CS_EXT_OSC;

  //////////////////////////////////////////////////////////////////////
  // source positions in the synchronised pin vector
  localparam int SRC_EXT_OSC = 0;
  localparam int SRC_LOW_POWER = 1;
  localparam int SRC_INT_REF = 2;

  //////////////////////////////////////////////////////////////////////
  // divisor per prescale code; entry 0 unused (prescaler off)
  // group 0 serves source codes x0, group 1 serves codes x1
  typedef logic [DIV_W-1:0] ptc_div_t;
  localparam ptc_div_t DIV_GROUP0 [0:7] = '{
    12'h001, 12'h001, 12'h002, 12'h004,
    12'h008, 12'h010, 12'h020, 12'h040
  };
  localparam ptc_div_t DIV_GROUP1 [0:7] = '{
    12'h001, 12'h080, 12'h100, 12'h200,
    12'h400, 12'h800, 12'h064, 12'h3E8
  };

endpackage
